//--- sbit_pkg.sv
// Package: register map, field positions, timing and state types
package sbit_pkg;
  localparam int unsigned ADDR_W         = 5;
  localparam logic [4:0]  OFS_CTRL       = 5'h00;
  localparam logic [4:0]  OFS_BAUD       = 5'h04;
  localparam logic [4:0]  OFS_DATA       = 5'h08;
  localparam logic [4:0]  OFS_STAT       = 5'h0c;
  localparam int unsigned CTRL_BRK_BIT   = 0;
  localparam int unsigned CTRL_TE_BIT    = 1;
  localparam int unsigned CTRL_M_BIT     = 2;
  localparam logic [7:0]  BAUD_RESET     = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [3:0]  FRAME_BITS_M0  = 4'ha;
  localparam logic [3:0]  FRAME_BITS_M1  = 4'hb;
  localparam logic [14:0] BAUD_OVS       = 15'h0010;
  localparam logic [14:0] PRE_DIV_0      = 15'h0001;
  localparam logic [14:0] PRE_DIV_1      = 15'h0003;
  localparam logic [14:0] PRE_DIV_2      = 15'h0004;
  localparam logic [14:0] PRE_DIV_3      = 15'h000d;
  localparam int unsigned FIFO_DEPTH     = 2;

  typedef enum logic [1:0] {S_IDLE, S_IDLEF, S_BREAK, S_DATA} sbit_fsm_type;

  typedef struct packed {
    logic              aw_v;
    logic [4:0]        aw_a;
    logic              w_v;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              send_break_bit;
    logic              te;
    logic              m;
    logic [7:0]        brr;
    logic              idle_req;
    logic              brk_pend;
    sbit_fsm_type      state;
    logic [14:0]       tick;
    logic [3:0]        bitn;
    logic [3:0]        frame_bits;
    logic [10:0]       shreg;
    logic              tx;
    logic [1:0][8:0]   fifo;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } sbit_state_type;
endpackage

//--- sbit_rx_model.sv
// Remote receiver model that times the low runs on the serial line
`timescale 1ns/1ps
`default_nettype none
module sbit_rx_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic line_in,
  output var  int   low_len,
  output var  int   low_cnt
);
  int run;

  // A run is only counted once the line is high again, so a stretched break
  // shows up as one long run rather than two
  always @(posedge aclk) begin
    if (!aresetn) begin
      run <= 0;
      low_len <= 0;
      low_cnt <= 0;
    end else if (line_in === 1'b0) begin
      run <= run + 1;
    end else if (run != 0) begin
      low_len <= run;
      low_cnt <= low_cnt + 1;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

//--- sbit_tx.sv
// Break, idle and data transmitter with an AXI4-Lite register slave
// What this block does
// (R1) Set then clear break sends one break
// (R2) Eight-bit word length: break lasts ten bits
// (R3) Nine-bit word length: break lasts eleven bits
// (R4) Breaks repeat while break bit stays set
// (R5) Enable toggle queues idle frame before next
// (R6) Idle then break gives nominal break length
// (R7) Software keeps idle and break requests adjacent
// (R8) Baud select divides clock into bit period
// (R9) No stretched break, none after clearing
`timescale 1ns/1ps
`default_nettype none
module sbit_tx
  import sbit_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   tx_out
);
  sbit_state_type st_r;
  sbit_state_type st_nxt;
  logic [14:0]    bit_ticks;
  logic           bit_end;
  logic           last_bit;
  logic           fifo_full;
  logic           wr_go;
  logic           wr_data;

  // Prescaler in bits 7:6, power-of-two divider in bits 2:0
  always_comb begin
    logic [14:0] pr;
    pr = PRE_DIV_0;
    case (st_r.brr[7:6])
      2'h0: pr = PRE_DIV_0;
      2'h1: pr = PRE_DIV_1;
      2'h2: pr = PRE_DIV_2;
      default: pr = PRE_DIV_3;
    endcase
    bit_ticks = 15'((BAUD_OVS * pr) << st_r.brr[2:0]); // R8
  end

  assign bit_end   = (st_r.tick == bit_ticks - 15'h0001);
  assign last_bit  = (st_r.bitn == st_r.frame_bits - 4'h1);
  assign fifo_full = (st_r.cnt == 2'(FIFO_DEPTH));
  assign wr_data   = (st_r.aw_a == OFS_DATA);
  // A full buffer holds the data write back, so no word is lost
  assign wr_go     = st_r.aw_v && st_r.w_v && !st_r.bvalid &&
                     !(wr_data && fifo_full);

  assign s_axi_awready = !st_r.aw_v;
  assign s_axi_wready  = !st_r.w_v;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign tx_out        = st_r.tx;

  always_comb begin
    logic         new_sbk;
    logic         new_te;
    logic         push;
    logic         pop;
    logic         frame_go;
    sbit_fsm_type pick;
    new_sbk  = 1'b0;
    new_te   = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    frame_go = 1'b0;
    pick     = S_IDLE;
    st_nxt   = st_r;

    if (s_axi_awvalid && !st_r.aw_v) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_v) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_d = s_axi_wdata;
      st_nxt.w_s = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.aw_v   = 1'b0;
      st_nxt.w_v    = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      if (st_r.aw_a == OFS_CTRL) begin
        if (st_r.w_s[0]) begin
          new_sbk   = st_r.w_d[CTRL_BRK_BIT];
          new_te    = st_r.w_d[CTRL_TE_BIT];
          st_nxt.send_break_bit = new_sbk;
          st_nxt.te  = new_te;
          st_nxt.m   = st_r.w_d[CTRL_M_BIT];
        end
      end else if (st_r.aw_a == OFS_BAUD) begin
        if (st_r.w_s[0]) begin
          st_nxt.brr = st_r.w_d[7:0];
        end
      end else if (wr_data) begin
        push = st_r.w_s[0];
      end else if (st_r.aw_a != OFS_STAT) begin
        st_nxt.bresp = RESP_SLVERR;
      end
    end

    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      if (s_axi_araddr == OFS_CTRL) begin
        st_nxt.rdata[2:0] = {st_r.m, st_r.te, st_r.send_break_bit};
      end else if (s_axi_araddr == OFS_BAUD) begin
        st_nxt.rdata[7:0] = st_r.brr;
      end else if (s_axi_araddr == OFS_DATA) begin
        st_nxt.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == OFS_STAT) begin
        st_nxt.rdata[5:0] = {st_r.tx, st_r.brk_pend, st_r.idle_req,
                             st_r.cnt == 2'h0, fifo_full,
                             st_r.state != S_IDLE};
      end else begin
        st_nxt.rresp = RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Next frame chosen once, both from rest and at a frame's end
    if (st_r.te) begin
      if (st_r.idle_req) begin
        pick = S_IDLEF; // R5
      end else if (st_r.brk_pend || st_r.send_break_bit) begin
        pick = S_BREAK; // R4
      end else if (st_r.cnt != 2'h0) begin
        pick = S_DATA;
      end
    end

    if (st_r.state == S_IDLE) begin
      frame_go = (pick != S_IDLE);
    end else begin
      st_nxt.tick = st_r.tick + 15'h0001;
      if (bit_end) begin
        st_nxt.tick  = 15'h0000;
        st_nxt.bitn  = st_r.bitn + 4'h1;
        st_nxt.shreg = {1'b1, st_r.shreg[10:1]};
        if (last_bit) begin
          // Break ends on its own count; the level alone can repeat it
          st_nxt.state = S_IDLE; // R9
          frame_go     = (pick != S_IDLE); // R6
        end
      end
    end

    if (frame_go) begin
      st_nxt.state      = pick;
      st_nxt.tick       = 15'h0000;
      st_nxt.bitn       = 4'h0;
      st_nxt.frame_bits = st_r.m ? FRAME_BITS_M1 : FRAME_BITS_M0; // R2 R3
      if (pick == S_IDLEF) begin
        st_nxt.idle_req = 1'b0;
      end else if (pick == S_BREAK) begin
        st_nxt.brk_pend = 1'b0; // R9
      end else begin
        pop = 1'b1;
        if (st_r.m) begin
          st_nxt.shreg = {1'b1, st_r.fifo[st_r.rp], 1'b0};
        end else begin
          st_nxt.shreg = {2'h3, st_r.fifo[st_r.rp][7:0], 1'b0};
        end
      end
    end

    // Requests set after the consuming clear, so a new event wins
    if (new_sbk && !st_r.send_break_bit && wr_go) begin
      st_nxt.brk_pend = 1'b1; // R1
    end
    if (new_te && !st_r.te && wr_go) begin
      st_nxt.idle_req = 1'b1; // R5
    end

    if (push) begin
      st_nxt.fifo[st_r.wp] = {st_r.w_s[1] & st_r.w_d[8], st_r.w_d[7:0]};
      st_nxt.wp = !st_r.wp;
    end
    if (pop) begin
      st_nxt.rp = !st_r.rp;
    end
    st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);

    case (st_nxt.state)
      S_BREAK: st_nxt.tx = 1'b0; // R1
      S_DATA:  st_nxt.tx = st_nxt.shreg[0];
      default: st_nxt.tx = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= '0;
      st_r.state <= S_IDLE;
      st_r.brr   <= BAUD_RESET;
      st_r.tx    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  brk_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    st_r.state == S_BREAK |-> tx_out == 1'b0)
    else $error("Line not low during break");
  len_ten_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (st_r.state != S_BREAK && st_nxt.state == S_BREAK && !st_r.m)
    |=> st_r.frame_bits == FRAME_BITS_M0)
    else $error("Break length not ten bits");
  len_eleven_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    (st_r.state != S_BREAK && st_nxt.state == S_BREAK && st_r.m)
    |=> st_r.frame_bits == FRAME_BITS_M1)
    else $error("Break length not eleven bits");
  brk_repeat_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    (st_r.state == S_BREAK && bit_end && last_bit && st_r.send_break_bit &&
     st_r.te && !st_r.idle_req)
    |=> st_r.state == S_BREAK && st_r.bitn == 4'h0 && !tx_out)
    else $error("Break not repeated while bit set");
  idle_first_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (st_r.state == S_IDLE && st_r.idle_req && st_r.te)
    |=> st_r.state == S_IDLEF ##1 tx_out)
    else $error("Idle frame not sent first");
  brk_end_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (st_r.state == S_BREAK && bit_end && last_bit && !st_r.send_break_bit &&
     !st_r.brk_pend) |=> st_r.state != S_BREAK)
    else $error("Extra break after clearing");
  brk_bits_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    st_r.state == S_BREAK |-> st_r.bitn < st_r.frame_bits)
    else $error("Break stretched beyond frame");
  baud_tick_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (st_r.state != S_IDLE && !bit_end && $stable(st_r.brr))
    |=> st_r.tick == $past(st_r.tick) + 15'h0001)
    else $error("Bit timer not counting");
  fifo_cnt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.cnt <= 2'h2)
    else $error("Buffer count overflow");
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the break and idle transmitter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbit_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd, r;
  logic [3:0]        s_axi_wstrb;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0]        s_axi_bresp, s_axi_rresp, br, rr;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, tx_out;
  int                low_len, low_cnt, n_mismatch, n_checks, seed, exp_cnt;

  always #10 aclk = ~aclk;

  sbit_tx DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_out);
  sbit_rx_model rx (.aclk, .aresetn, .line_in(tx_out), .low_len, .low_cnt);

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Ready is comb from state, so it is looked at mid-cycle where it is settled
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdreg(input logic [4:0] a);
    logic ar, v;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (v !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic int ticks(input logic [7:0] b);
    int p;
    case (b[7:6])
      2'h0: p = 1;
      2'h1: p = 3;
      2'h2: p = 4;
      default: p = 13;
    endcase
    return 16 * p * (1 << b[2:0]);
  endfunction

  // Waits for c more low runs; a run that never comes ends the test
  task automatic wait_runs(input int c);
    int k;
    exp_cnt += c;
    k = 0;
    while (low_cnt != exp_cnt && k < 30000) begin
      @(posedge aclk);
      k++;
    end
    if (low_cnt != exp_cnt) begin
      check("run count", exp_cnt, low_cnt);
      conclude();
    end
  endtask

  // Idle request and break set in one write, then break cleared after hold cycles
  task automatic brk(input logic [7:0] b, input logic m, input int hold,
                     input int n);
    wr(OFS_BAUD, {24'h0, b});
    wr(OFS_CTRL, {29'h0, m, 2'b00});
    wr(OFS_CTRL, {29'h0, m, 2'b11});
    repeat (hold) @(posedge aclk);
    wr(OFS_CTRL, {29'h0, m, 2'b10});
    wait_runs(1);
    check("break length", n * ticks(b) * (m ? 11 : 10), low_len);
    repeat (ticks(b) * 2) @(posedge aclk);
    check("break count", exp_cnt, low_cnt);
    check("line idle", 32'h1, {31'h0, tx_out});
  endtask

  initial begin
    repeat (90000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    seed = 64;
    n_mismatch = 0;
    n_checks = 0;
    exp_cnt = 0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdreg(OFS_BAUD);
    check("baud reset", {24'h0, BAUD_RESET}, rd);
    rdreg(5'h10);
    check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    check("unmapped rdata", 32'h0, rd);
    wr(5'h14, 32'h3);
    check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, br});
    rdreg(OFS_CTRL);
    check("ctrl reset", 32'h0, rd);
    brk(8'hc9, 1'b0, 0, 1);
    // Held long enough to end inside the second break
    brk(8'h00, 1'b0, 400, 2);
    brk(8'h00, 1'b1, 0, 1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      brk({r[7:3], 2'b00, r[8]}, r[9], 0, 1);
    end
    // Two words wait while disabled; enabling sends an idle frame first
    wr(OFS_BAUD, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_DATA, 32'h0f0);
    wr(OFS_DATA, 32'h000);
    rdreg(OFS_STAT);
    check("status full", 32'h22, rd);
    wr(OFS_CTRL, 32'h2);
    repeat (140) @(posedge aclk);
    check("idle first", exp_cnt, low_cnt);
    wait_runs(2);
    check("data low run", 9 * ticks(8'h00), low_len);
    repeat (2 * ticks(8'h00)) @(posedge aclk);
    rdreg(OFS_STAT);
    check("status idle", 32'h24, rd);
    conclude();
  end
endmodule
`default_nettype wire
